// ### sdr_map.svh
/*
  Offsets, field positions, encodings and timing counts of the self refresh
  and precharge sequencer. Definitions only; included by the package user.
*/
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SDR_CTRL_OFS   4'h0
`define SDR_STAT_OFS   4'h4
`define SDR_RCNT_OFS   4'h8
`define SDR_CTRL_RST   16'h0500

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SDR_CF_BL      1:0
`define SDR_CF_MANTEMP 2
`define SDR_CF_AUTORATE 3
`define SDR_CF_AL      7:4
`define SDR_CF_CWL     11:8
`define SDR_BL_PERCMD  2'h1
`define SDR_BL_FIXBC4  2'h2

// ----------------------------------------------------------------
// Pin command codes {ras_n, cas_n, we_n} with cs_n low
// ----------------------------------------------------------------
`define SDR_CMD_REF    3'h1
`define SDR_CMD_PRE    3'h2
`define SDR_CMD_ACT    3'h3
`define SDR_CMD_WR     3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDR_CLK_NS     10
`define SDR_SRREF_NS   7800
`define SDR_SRREF_CYC  ((`SDR_SRREF_NS) / (`SDR_CLK_NS))
`define SDR_XS_CK      8'h10
`define SDR_RESP_OK    2'h0
`define SDR_RESP_DEC   2'h3

`endif

// ### sdr_pkg.sv
/*
  Types of the self refresh and precharge sequencer.
  Assumes nothing of its surroundings.
*/
package sdr_pkg;
    typedef enum logic [1:0] {sdr_run, sdr_self, sdr_wake, sdr_xs} sdr_state_t;
endpackage : sdr_pkg

// ### sdr_sync.sv
/*
  Two flip-flop synchroniser for a group of pins.
  Assumes the inputs are asynchronous to aclk.
*/
`timescale 1ns/10ps
module sdr_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,     // system clock
    input  wire logic         aresetn,  // sync reset, low
    input  wire logic [W-1:0] d,        // asynchronous pins
    output logic      [W-1:0] q         // synchronised copy
);
    logic [W-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sdr_sync

// ### sdr_seq.sv
/*
  Device-side command sequencer: bank open/idle tracking, PRECHARGE, write
  burst chop and latency, self refresh entry/exit with DLL control and
  internal refresh. Registers over AXI4-Lite.
  Assumes the memory pins are asynchronous to aclk and that ck is slow enough
  (several aclk periods) for its edges to be found by sampling.
*/
// What this block does
// - Mode bits 10 force four-beat chop
// - Mode bits 01: A12 low chops
// - A10 high precharges all, else BA
// - Precharged bank idle; activate before access
// - REFRESH with CKE low enters self refresh
// - DLL off on entry, reset on exit
// - In self refresh only CKE, reset matter
// - One internal refresh right after entry
// - Exit asynchronous; count from first edge
// - Write latency equals AL plus CWL
`timescale 1ns/10ps
`include "sdr_map.svh"
module sdr_seq
    import sdr_pkg::*;
(
    input  wire logic        aclk,          // system clock
    input  wire logic        aresetn,       // sync reset, low
    input  wire logic        awvalid,       // AXI write address
    output logic             awready,       // AXI
    input  wire logic [3:0]  awaddr,        // AXI
    input  wire logic        wvalid,        // AXI write data
    output logic             wready,        // AXI
    input  wire logic [31:0] wdata,         // AXI
    input  wire logic [3:0]  wstrb,         // AXI
    output logic             bvalid,        // AXI write response
    input  wire logic        bready,        // AXI
    output logic [1:0]       bresp,         // AXI
    input  wire logic        arvalid,       // AXI read address
    output logic             arready,       // AXI
    input  wire logic [3:0]  araddr,        // AXI
    output logic             rvalid,        // AXI read data
    input  wire logic        rready,        // AXI
    output logic [31:0]      rdata,         // AXI
    output logic [1:0]       rresp,         // AXI
    input  wire logic        ck,            // memory clock pin
    input  wire logic        cke,           // clock enable pin
    input  wire logic        cs_n,          // chip select, low
    input  wire logic        ras_n,         // row strobe, low
    input  wire logic        cas_n,         // column strobe, low
    input  wire logic        we_n,          // write enable, low
    input  wire logic [2:0]  ba,            // bank address
    input  wire logic        a10,           // all-banks select
    input  wire logic        a12,           // chop select
    input  wire logic        reset_pin_n,   // memory reset pin, low
    output logic             wr_window,     // first write strobe edge due
    output logic             wr_chop,       // that burst is four beats
    output logic             int_refresh,   // internal refresh pulse
    output logic             dll_on,        // DLL enabled
    output logic             dll_reset      // DLL reset pulse
);
    // ----------------------------------------------------------------
    // Pin capture
    // ----------------------------------------------------------------
    logic [11:0] pins;
    logic        ck_d;
    sdr_sync #(.W(12)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({reset_pin_n, ck, cke, cs_n, ras_n, cas_n, we_n, ba, a10, a12}),
        .q       (pins)
    );
    wire       rst_pin_s = ~pins[11];
    wire       ck_s      = pins[10];
    wire       cke_s     = pins[9];
    wire [3:0] cmd_s     = pins[8:5];
    wire [2:0] ba_s      = pins[4:2];
    wire       a10_s     = pins[1];
    wire       a12_s     = pins[0];
    wire       ck_rise   = ck_s & ~ck_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) ck_d <= 1'b0;
        else          ck_d <= ck_s;
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    sdr_state_t  state;
    logic [15:0] ctrl;
    logic [7:0]  bank_open;
    logic [7:0]  xs_cnt;
    logic [4:0]  wl_cnt;
    logic        wl_busy;
    logic        chop_pend;
    logic [9:0]  ref_tmr;
    logic [15:0] ref_count;

    function automatic logic is_cmd(input logic [3:0] c, input logic [2:0] code);
        is_cmd = (c == {1'b0, code});
    endfunction : is_cmd

    // Commands count only at a ck edge in normal running
    wire take     = ck_rise & (state == sdr_run) & cke_s;
    wire act_take = take & is_cmd(cmd_s, `SDR_CMD_ACT);
    wire pre_take = take & is_cmd(cmd_s, `SDR_CMD_PRE);
    wire wr_take  = take & is_cmd(cmd_s, `SDR_CMD_WR) & bank_open[ba_s];
    wire entry_take = ck_rise & (state == sdr_run) & ~cke_s & is_cmd(cmd_s, `SDR_CMD_REF);
    wire exit_edge = ck_rise & (state == sdr_wake) & cke_s;

    wire [1:0] bl_mode   = ctrl[`SDR_CF_BL];
    wire       chop_next = (bl_mode == `SDR_BL_FIXBC4) | ((bl_mode == `SDR_BL_PERCMD) & ~a12_s);
    wire [4:0] wl_load   = {1'b0, ctrl[`SDR_CF_AL]} + {1'b0, ctrl[`SDR_CF_CWL]};

    // ----------------------------------------------------------------
    // Bank state
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || rst_pin_s) begin
            bank_open <= 8'h00;
        end else if (act_take) begin
            bank_open[ba_s] <= 1'b1;
        end else if (pre_take) begin
            if (a10_s) bank_open <= 8'h00;
            else       bank_open[ba_s] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Write latency
    // ----------------------------------------------------------------
    // One pending write only; a second WRITE before the first strobe
    // edge restarts the count, which is enough for tCCD-spaced bursts.
    always_ff @(posedge aclk) begin
        if (!aresetn || rst_pin_s) begin
            wl_cnt    <= 5'h00;
            wl_busy   <= 1'b0;
            chop_pend <= 1'b0;
            wr_window <= 1'b0;
            wr_chop   <= 1'b0;
        end else begin
            wr_window <= 1'b0;
            if (wr_take) begin
                wl_cnt    <= wl_load;
                wl_busy   <= 1'b1;
                chop_pend <= chop_next;
            end else if (wl_busy && ck_rise) begin
                if (wl_cnt <= 5'h01) begin
                    wl_busy   <= 1'b0;
                    wr_window <= 1'b1;
                    wr_chop   <= chop_pend;
                end
                wl_cnt <= wl_cnt - 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Self refresh
    // ----------------------------------------------------------------
    // Exit is seen on the CKE level, since ck may be stopped; sdr_xs starts at the next ck edge.
    always_ff @(posedge aclk) begin
        if (!aresetn || rst_pin_s) begin
            state     <= sdr_run;
            dll_on    <= 1'b1;
            dll_reset <= 1'b0;
            xs_cnt    <= 8'h00;
        end else begin
            dll_reset <= 1'b0;
            case (state)
                sdr_run: if (entry_take) begin
                    state  <= sdr_self;
                    dll_on <= 1'b0;
                end
                sdr_self: if (cke_s) state <= sdr_wake;
                sdr_wake: if (exit_edge) begin
                    state     <= sdr_xs;
                    dll_on    <= 1'b1;
                    dll_reset <= 1'b1;
                    xs_cnt    <= 8'h00;
                end else if (!cke_s) begin
                    state <= sdr_self;
                end
                sdr_xs: if (ck_rise) begin
                    if (xs_cnt == `SDR_XS_CK - 8'h01) state <= sdr_run;
                    xs_cnt <= xs_cnt + 8'h01;
                end
                default: state <= sdr_run;
            endcase
        end
    end

    // Refresh timer runs on aclk: the memory clock may stop in self refresh
    wire       fast_ref = ctrl[`SDR_CF_MANTEMP] | ctrl[`SDR_CF_AUTORATE];
    wire [9:0] ref_ivl  = fast_ref ? 10'(`SDR_SRREF_CYC / 2) : 10'(`SDR_SRREF_CYC);
    wire       ref_due  = (state == sdr_self) && (ref_tmr >= ref_ivl - 10'h001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_tmr     <= 10'h000;
            int_refresh <= 1'b0;
            ref_count   <= 16'h0000;
        end else begin
            int_refresh <= entry_take | ref_due;
            ref_tmr     <= (entry_take | ref_due) ? 10'h000 : ref_tmr + 10'h001;
            if (entry_take | ref_due) ref_count <= ref_count + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = `SDR_CTRL_RST;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         wr_do  = aw_held & w_held & ~bvalid;
    wire         wr_hit = (aw_addr == `SDR_CTRL_OFS);
    wire         rd_hit = (araddr == `SDR_CTRL_OFS) | (araddr == `SDR_STAT_OFS) | (araddr == `SDR_RCNT_OFS);
    wire [11:0]  stat   = {chop_pend, (state == sdr_xs) | (state == sdr_wake), dll_on, state == sdr_self, bank_open};
    wire [31:0]  rd_mux = (araddr == `SDR_CTRL_OFS) ? {16'h0000, ctrl} :
                          (araddr == `SDR_STAT_OFS) ? {20'h00000, stat} :
                          (araddr == `SDR_RCNT_OFS) ? {16'h0000, ref_count} : 32'h00000000;

    assign awready = ~aw_held & ~bvalid;
    assign wready  = ~w_held & ~bvalid;
    assign arready = ~rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `SDR_RESP_OK;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wr_hit | (aw_addr == `SDR_STAT_OFS) | (aw_addr == `SDR_RCNT_OFS)) ?
                           `SDR_RESP_OK : `SDR_RESP_DEC;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // One register process for ctrl; the lanes only pick the next bytes
    wire [15:0] next_ctrl;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            assign next_ctrl[g*8 +: 8] = (wr_do && wr_hit && w_strb[g]) ? w_data[g*8 +: 8] : ctrl[g*8 +: 8];
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) ctrl <= CTRL_RST;
        else          ctrl <= next_ctrl;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `SDR_RESP_OK;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= rd_hit ? `SDR_RESP_OK : `SDR_RESP_DEC;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    fixed_chop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && bl_mode == `SDR_BL_FIXBC4 && !rst_pin_s) |=> chop_pend) else $error("fixed chop not taken");
    percmd_chop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && bl_mode == `SDR_BL_PERCMD && !rst_pin_s) |=> (chop_pend == !$past(a12_s)))
        else $error("per-command chop wrong");
    pre_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pre_take && a10_s) |=> (bank_open == 8'h00)) else $error("all-bank precharge missed");
    pre_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pre_take && !a10_s) |=> (!bank_open[$past(ba_s)] &&
        ((bank_open | (8'h01 << $past(ba_s))) == ($past(bank_open) | (8'h01 << $past(ba_s))))))
        else $error("single-bank precharge wrong");
    idle_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && is_cmd(cmd_s, `SDR_CMD_WR) && !bank_open[ba_s] && !wl_busy) |=> !wl_busy)
        else $error("write to idle bank accepted");
    sr_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (entry_take && !rst_pin_s) |=> (state == sdr_self) && !dll_on) else $error("self refresh entry missed");
    dll_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (exit_edge && !rst_pin_s) |=> dll_on && dll_reset ##1 !dll_reset) else $error("DLL not reset on exit");
    sr_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == sdr_self && !rst_pin_s) |=> $stable(bank_open)) else $error("command acted on in self refresh");
    int_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
        entry_take |=> int_refresh) else $error("no refresh after entry");
    xs_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == sdr_wake && !exit_edge && !rst_pin_s && cke_s) |=> (state == sdr_wake))
        else $error("exit interval started without ck edge");
    wl_window_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_window |-> $past(wl_busy) && ($past(wl_cnt) <= 5'h01)) else $error("strobe window off latency");
endmodule : sdr_seq

// ### sdr_ctl_model.sv
/*
  Memory controller model: makes the memory clock and drives CKE, the
  command pins and the memory reset pin. Assumes the sequencer samples the
  pins on rising ck edges; commands change on falling edges only.
*/
`timescale 1ns/10ps
module sdr_ctl_model (
    output logic       ck,          // memory clock, 160 ns
    output logic       cke,         // clock enable
    output logic       cs_n,        // chip select, low
    output logic       ras_n,       // row strobe, low
    output logic       cas_n,       // column strobe, low
    output logic       we_n,        // write enable, low
    output logic [2:0] ba,          // bank address
    output logic       a10,         // all-banks select
    output logic       a12,         // chop select
    output logic       reset_pin_n  // memory reset, low
);
    // No strobe, data or ODT pins: the sequencer has none
    // Deselected lines carry noise so a stale command never looks valid
    task deselect();
        cs_n = 1'b1;
        {ras_n, cas_n, we_n, a10, a12, ba} = 8'($urandom);
    endtask : deselect

    initial begin
        ck = 1'b0;
        cke = 1'b1;
        reset_pin_n = 1'b1;
        deselect();
        #3;
        forever #80 ck = ~ck; // Free-running, never altered
    end

    // One command across a rising edge, deselect on the next half clock
    task issue(input logic [2:0] cmd, input logic [2:0] b, input logic ap, input logic chop, input logic en);
        @(negedge ck);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = cmd;
        ba = b;
        a10 = ap;
        a12 = chop;
        cke = en;
        @(negedge ck);
        deselect();
    endtask : issue

    // Idle clocks with CKE held at en
    task nop(input int n, input logic en);
        repeat (n) begin
            @(negedge ck);
            cke = en;
            deselect();
        end
    endtask : nop

    task pin_reset();
        @(negedge ck);
        reset_pin_n = 1'b0;
        repeat (2) @(negedge ck);
        reset_pin_n = 1'b1;
    endtask : pin_reset
endmodule : sdr_ctl_model

// ### tb_top.sv
/*
  Testbench of the sequencer: AXI4-Lite master, controller model on the pins,
  expectation queue for write windows. Assumes the design files compiled first.
*/
`timescale 1ns/10ps
`include "sdr_map.svh"
module tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, cv;
    logic [1:0]  bresp, rresp;
    logic        ck, cke, cs_n, ras_n, cas_n, we_n, a10, a12, reset_pin_n;
    logic [2:0]  ba, b;
    logic        wr_window, wr_chop, int_refresh, dll_on, dll_reset, chk_chop, exp_chop;
    int          num_errors, samples_checked, ck_cnt, ref_cnt, dllr_cnt;
    int          i, al, cwl, per, rc, n;
    typedef struct { int wl; int edge_no; logic chop; } sdr_exp_t;
    sdr_exp_t    exp_q[$];

    sdr_seq dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10), .a12(a12), .reset_pin_n(reset_pin_n),
        .wr_window(wr_window), .wr_chop(wr_chop), .int_refresh(int_refresh), .dll_on(dll_on),
        .dll_reset(dll_reset));
    sdr_ctl_model ctl_u (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .a10(a10), .a12(a12), .reset_pin_n(reset_pin_n));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task timeout(input string name);
        num_errors++;
        $display("BAD %s expected answer seen timeout", name);
        stop_test();
    endtask : timeout

    // ----------------------------------------------------------------
    // Monitor: events counted, windows matched against the queue
    // ----------------------------------------------------------------
    always @(posedge ck) ck_cnt <= ck_cnt + 1;
    always @(posedge aclk) begin
        if (int_refresh === 1'b1) ref_cnt <= ref_cnt + 1;
        if (dll_reset === 1'b1) dllr_cnt <= dllr_cnt + 1;
        if (chk_chop) begin
            chk("burst chop", 32'(wr_chop), 32'(exp_chop));
            chk_chop <= 1'b0;
        end
        if (wr_window === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected window", 32'h1, 32'h0);
            end else begin
                chk("write latency", ck_cnt - exp_q[0].edge_no, exp_q[0].wl);
                exp_chop <= exp_q[0].chop;
                chk_chop <= 1'b1;
                void'(exp_q.pop_front());
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite master; ready sampled mid-cycle, released after the edge
    // ----------------------------------------------------------------
    task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (200) begin
            @(negedge aclk);
            aw_go = awvalid & awready;
            w_go = wvalid & wready;
            b_go = bvalid & bready;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            if (b_go) begin
                bready <= 1'b0;
                chk("write response", 32'(bresp), 32'(er));
                return;
            end
        end
        timeout("write response");
    endtask : axi_write

    task rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er, input string name);
        logic ar_go, r_go;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (200) begin
            @(negedge aclk);
            ar_go = arvalid & arready;
            r_go = rvalid & rready;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            if (r_go) begin
                rready <= 1'b0;
                chk(name, rdata, e);
                chk("read response", 32'(rresp), 32'(er));
                return;
            end
        end
        timeout(name);
    endtask : rd_chk

    task wait_refresh(output int cyc);
        cyc = 0;
        do begin
            @(negedge aclk);
            cyc++;
        end while (int_refresh !== 1'b1 && cyc < 2000);
        if (cyc >= 2000) timeout("internal refresh");
    endtask : wait_refresh

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, chk_chop, exp_chop} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {num_errors, samples_checked, ck_cnt, ref_cnt, dllr_cnt} = '0;
        void'($urandom(72));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`SDR_CTRL_OFS, 32'h0000_0500, `SDR_RESP_OK, "ctrl reset");
        rd_chk(`SDR_STAT_OFS, 32'h0000_0200, `SDR_RESP_OK, "stat reset");
        rd_chk(`SDR_RCNT_OFS, 32'h0, `SDR_RESP_OK, "rcnt reset");
        rd_chk(4'hC, 32'h0, `SDR_RESP_DEC, "unmapped read");
        axi_write(4'hC, 32'hFFFF_FFFF, 4'hF, `SDR_RESP_DEC);
        axi_write(`SDR_STAT_OFS, 32'hFFFF_FFFF, 4'hF, `SDR_RESP_OK);
        rd_chk(`SDR_STAT_OFS, 32'h0000_0200, `SDR_RESP_OK, "stat read only");
        axi_write(`SDR_CTRL_OFS, 32'h0000_ABCD, 4'h1, `SDR_RESP_OK);
        rd_chk(`SDR_CTRL_OFS, 32'h0000_05CD, `SDR_RESP_OK, "ctrl byte strobe");
        $display("test registers done");

        ctl_u.issue(`SDR_CMD_ACT, 3'h2, 1'b0, 1'b0, 1'b1);
        ctl_u.issue(`SDR_CMD_ACT, 3'h5, 1'b0, 1'b0, 1'b1);
        rd_chk(`SDR_STAT_OFS, 32'h0000_0224, `SDR_RESP_OK, "banks open");
        ctl_u.issue(`SDR_CMD_PRE, 3'h2, 1'b0, 1'b0, 1'b1);
        rd_chk(`SDR_STAT_OFS, 32'h0000_0220, `SDR_RESP_OK, "one bank closed");
        ctl_u.issue(`SDR_CMD_ACT, 3'h2, 1'b0, 1'b0, 1'b1);
        ctl_u.issue(`SDR_CMD_PRE, 3'h2, 1'b1, 1'b0, 1'b1);
        rd_chk(`SDR_STAT_OFS, 32'h0000_0200, `SDR_RESP_OK, "all banks closed");
        ctl_u.issue(`SDR_CMD_ACT, 3'h1, 1'b0, 1'b0, 1'b1);
        ctl_u.pin_reset();
        rd_chk(`SDR_STAT_OFS, 32'h0000_0200, `SDR_RESP_OK, "pin reset banks");
        $display("test banks done");

        // Modes {0,1,1,2,2}, A12 and expected chop per entry
        for (i = 0; i < 5; i++) begin
            al = $urandom_range(3);
            cwl = $urandom_range(8, 5);
            b = 3'($urandom);
            cv = {20'h0, 4'(cwl), 4'(al), 2'b00, 2'(10'b10_10_01_01_00 >> (2 * i))};
            axi_write(`SDR_CTRL_OFS, cv, 4'h3, `SDR_RESP_OK);
            ctl_u.issue(`SDR_CMD_ACT, b, 1'b0, 1'b0, 1'b1);
            ctl_u.issue(`SDR_CMD_WR, b, 1'b0, 5'b01101 >> i & 5'h1, 1'b1);
            exp_q.push_back('{al + cwl, ck_cnt, 5'b11010 >> i & 5'h1});
            for (n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge aclk);
            if (n >= 300) timeout("write window");
            ctl_u.nop(4, 1'b1);
            ctl_u.issue(`SDR_CMD_PRE, b, 1'b0, 1'b0, 1'b1);
            ctl_u.issue(`SDR_CMD_WR, b, 1'b0, 1'b0, 1'b1);
            ctl_u.nop(12, 1'b1);
        end
        $display("test writes done");

        for (i = 0; i < 3; i++) begin
            per = (i == 0) ? 780 : 390;
            axi_write(`SDR_CTRL_OFS, 32'h0500 | (32'h2 << i) & 32'hC, 4'h3, `SDR_RESP_OK);
            rc = ref_cnt;
            ctl_u.issue(`SDR_CMD_REF, 3'h0, 1'b0, 1'b0, 1'b0);
            chk("entry refresh", ref_cnt - rc, 32'h1);
            chk("dll off", 32'(dll_on), 32'h0);
            rd_chk(`SDR_STAT_OFS, 32'h0000_0900, `SDR_RESP_OK, "in self refresh");
            wait_refresh(n);
            wait_refresh(n);
            chk("refresh interval", n, per);
            ctl_u.issue(`SDR_CMD_ACT, 3'h1, 1'b0, 1'b0, 1'b0);
            rc = dllr_cnt;
            ctl_u.nop(1, 1'b1);
            ctl_u.issue(`SDR_CMD_ACT, 3'h3, 1'b0, 1'b0, 1'b1);
            chk("dll reset", dllr_cnt - rc, 32'h1);
            chk("dll on", 32'(dll_on), 32'h1);
            ctl_u.nop(16, 1'b1);
            ctl_u.issue(`SDR_CMD_ACT, 3'h4, 1'b0, 1'b0, 1'b1);
            rd_chk(`SDR_STAT_OFS, 32'h0000_0A10, `SDR_RESP_OK, "after exit");
            rd_chk(`SDR_RCNT_OFS, 32'(ref_cnt), `SDR_RESP_OK, "refresh count");
            ctl_u.issue(`SDR_CMD_PRE, 3'h0, 1'b1, 1'b0, 1'b1);
        end
        $display("test self refresh done");
        stop_test();
    end
endmodule : tb_top
